/* hw/cfgst_pkg.sv */
package cfgst_pkg;
    localparam int ADDR_W = 12;
    localparam int NV_AW = 10;
    localparam logic [11:0] STATUS_SEL_REG = 12'h01d;
    localparam int STATUS_SEL_BIT = 7;
    localparam logic [11:0] REG_PROGRESS = 12'hb00;
    localparam logic [11:0] REG_DATA_ERROR = 12'hb01;
    localparam logic [11:0] REG_STORE_CONTROL = 12'hb02;
    localparam logic [11:0] REG_SAVE_START = 12'hb03;
    localparam int PROGRESS_BIT = 0;
    localparam int ERROR_BIT = 0;
    localparam int WR_ENABLE_BIT = 0;
    localparam int SOFT_LOAD_BIT = 1;
    localparam int SAVE_START_BIT = 0;
    localparam logic WR_ENABLE_RESET = 1'b0;
    localparam logic [11:0] SEG_FIRST = 12'ha00;
    localparam logic [11:0] SEG_LAST = 12'haff;
    localparam int CMD_OPCODE_BIT = 7;
    localparam logic [7:0] OP_UPDATE = 8'h80;
    localparam logic [7:0] OP_END = 8'hff;
    localparam logic [1:0] PH_CMD = 2'h0;
    localparam logic [1:0] PH_AHI = 2'h1;
    localparam logic [1:0] PH_ALO = 2'h2;
    localparam real CLK_NS = 20.0;
    localparam real GAP_US = 10.0;
    localparam int GAP_CYC = int'((GAP_US * 1000.0 + CLK_NS - 1.0) / CLK_NS);

    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH, ST_FETCHW, ST_SRC, ST_SRCW, ST_DST, ST_DONE
    } cfgst_state_t;
endpackage

/* hw/cfgst_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module cfgst_ctrl import cfgst_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic status_sel_i,
    output logic status_o,
    input wire logic store_sel_i,
    output logic soft_reset_o,
    output logic update_o,
    output logic [11:0] buf_addr_o,
    output logic buf_rd_o,
    input wire logic [7:0] buf_rdata_i,
    output logic buf_wr_o,
    output logic [7:0] buf_wdata_o,
    output logic nv_req_o,
    output logic nv_we_o,
    output logic [9:0] nv_addr_o,
    output logic [7:0] nv_wdata_o,
    input wire logic nv_ack_i,
    input wire logic [7:0] nv_rdata_i,
    input wire logic nv_err_i
);
    typedef struct packed {
        cfgst_state_t st;
        logic save;
        logic wr_en;
        logic err;
        logic [1:0] phase;
        logic [11:0] seg_ptr;
        logic [6:0] cnt;
        logic [11:0] dptr;
        logic [9:0] nv_ptr;
        logic [7:0] data;
        logic [7:0] rdata;
        logic [2:0] sel_sync;
        logic sel_lvl;
        logic soft_rst;
        logic upd;
    } cfgst_regs_t;

    cfgst_regs_t s_r;
    cfgst_regs_t s_nxt;
    logic busy;
    logic sel_low;
    logic is_save_wr;
    logic is_load_wr;

    assign busy = (s_r.st != ST_IDLE);
    // Pin level only moves once the second and third stages agree
    assign sel_low = !s_r.sel_lvl;
    assign is_save_wr = reg_wr_i && reg_addr_i == REG_SAVE_START
        && reg_wdata_i[SAVE_START_BIT];
    assign is_load_wr = reg_wr_i && reg_addr_i == REG_STORE_CONTROL
        && reg_wdata_i[SOFT_LOAD_BIT];

    always_comb begin
        s_nxt = s_r;
        s_nxt.soft_rst = 1'b0;
        s_nxt.upd = 1'b0;
        s_nxt.sel_sync = {s_r.sel_sync[1:0], store_sel_i};
        if (s_r.sel_sync[1] == s_r.sel_sync[2]) begin
            s_nxt.sel_lvl = s_r.sel_sync[2];
        end
        if (reg_wr_i && reg_addr_i == REG_STORE_CONTROL) begin
            s_nxt.wr_en = reg_wdata_i[WR_ENABLE_BIT];
        end
        if (reg_addr_i == REG_PROGRESS) begin
            s_nxt.rdata = {7'h00, busy};
        end else if (reg_addr_i == REG_DATA_ERROR) begin
            s_nxt.rdata = {7'h00, s_r.err};
        end else if (reg_addr_i == REG_STORE_CONTROL) begin
            // Soft load bit self-clears, so it always reads back 0
            s_nxt.rdata = {7'h00, s_r.wr_en};
        end else if (reg_addr_i == REG_SAVE_START) begin
            s_nxt.rdata = {7'h00, busy && s_r.save};
        end else begin
            s_nxt.rdata = 8'h00;
        end
        case (s_r.st)
            ST_IDLE: begin
                // Requests during a transfer are dropped, not queued
                if (is_save_wr && s_r.wr_en) begin
                    s_nxt.save = 1'b1;
                    s_nxt.st = ST_FETCH;
                end else if (is_load_wr && sel_low) begin
                    s_nxt.save = 1'b0;
                    s_nxt.soft_rst = 1'b1;
                    s_nxt.st = ST_FETCH;
                end
                s_nxt.seg_ptr = SEG_FIRST;
                s_nxt.phase = PH_CMD;
                s_nxt.nv_ptr = 10'h000;
                if (s_nxt.st == ST_FETCH) begin
                    s_nxt.err = 1'b0;
                end
            end
            ST_FETCH: begin
                s_nxt.st = ST_FETCHW;
            end
            ST_FETCHW: begin
                s_nxt.data = buf_rdata_i;
                s_nxt.seg_ptr = s_r.seg_ptr + 12'h001;
                s_nxt.st = ST_FETCH;
                if (s_r.phase == PH_CMD) begin
                    if (!buf_rdata_i[CMD_OPCODE_BIT]) begin
                        s_nxt.cnt = buf_rdata_i[6:0];
                        s_nxt.phase = PH_AHI;
                    end else if (buf_rdata_i == OP_END) begin
                        s_nxt.st = ST_DONE;
                    end else if (buf_rdata_i == OP_UPDATE) begin
                        s_nxt.upd = 1'b1;
                    end
                end else if (s_r.phase == PH_AHI) begin
                    s_nxt.dptr = {buf_rdata_i[3:0], 8'h00};
                    s_nxt.phase = PH_ALO;
                end else begin
                    s_nxt.dptr = {s_r.dptr[11:8], buf_rdata_i};
                    s_nxt.phase = PH_CMD;
                    s_nxt.st = ST_SRC;
                end
                // Segment ran out without an end order: flag and stop
                if (s_r.seg_ptr == SEG_LAST && s_nxt.st == ST_FETCH) begin
                    s_nxt.err = 1'b1;
                    s_nxt.st = ST_DONE;
                end
            end
            ST_SRC: begin
                if (s_r.save) begin
                    s_nxt.st = ST_SRCW;
                end else if (nv_ack_i) begin
                    s_nxt.data = nv_rdata_i;
                    s_nxt.err = s_r.err | nv_err_i;
                    s_nxt.st = ST_DST;
                end
            end
            ST_SRCW: begin
                s_nxt.data = buf_rdata_i;
                s_nxt.st = ST_DST;
            end
            ST_DST: begin
                if (!s_r.save || nv_ack_i) begin
                    if (s_r.save) begin
                        s_nxt.err = s_r.err | nv_err_i;
                    end
                    s_nxt.nv_ptr = s_r.nv_ptr + 10'h001;
                    s_nxt.dptr = s_r.dptr + 12'h001;
                    s_nxt.cnt = s_r.cnt - 7'h01;
                    s_nxt.st = (s_r.cnt == 7'h00) ? ST_FETCH : ST_SRC;
                end
            end
            ST_DONE: begin
                s_nxt.save = 1'b0;
                s_nxt.st = ST_IDLE;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Select pin starts high so no load slips in before it settles
            s_r <= '{st: ST_IDLE, wr_en: WR_ENABLE_RESET, seg_ptr: SEG_FIRST,
                sel_sync: 3'h7, sel_lvl: 1'h1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata_o = s_r.rdata;
    assign status_o = status_sel_i && busy;
    assign soft_reset_o = s_r.soft_rst;
    assign update_o = s_r.upd;
    assign buf_rd_o = (s_r.st == ST_FETCH) || (s_r.st == ST_SRC && s_r.save);
    assign buf_addr_o = (s_r.st == ST_FETCH) ? s_r.seg_ptr : s_r.dptr;
    assign buf_wr_o = (s_r.st == ST_DST) && !s_r.save;
    assign buf_wdata_o = s_r.data;
    assign nv_req_o = (s_r.st == ST_DST && s_r.save)
        || (s_r.st == ST_SRC && !s_r.save);
    // Store writes only happen on a save, which protection already gates
    assign nv_we_o = s_r.save && s_r.st == ST_DST;
    assign nv_addr_o = s_r.nv_ptr;
    assign nv_wdata_o = s_r.data;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    chk_progress_read: assert property (
        reg_addr_i == REG_PROGRESS |=> reg_rdata_o == {7'h00, $past(busy)})
        else $error("progress flag read wrong");
    chk_status_pin: assert property (
        status_sel_i && !busy && is_save_wr && s_r.wr_en ##1 status_sel_i
        |-> status_o) else $error("status pin not showing progress");
    chk_error_read: assert property (
        reg_addr_i == REG_DATA_ERROR |=> reg_rdata_o[0] == $past(s_r.err))
        else $error("error flag read wrong");
    chk_soft_load: assert property (
        !busy && is_load_wr && sel_low && !is_save_wr
        |=> soft_reset_o && busy && !s_r.save ##1 !soft_reset_o)
        else $error("soft load not started");
    chk_protect_write: assert property (
        $rose(s_r.save) |-> $past(s_r.wr_en))
        else $error("save started while protected");
    chk_save_held: assert property (
        busy && s_r.save && s_r.st != ST_DONE |=> s_r.save)
        else $error("save bit dropped early");
    chk_cmd_count: assert property (
        s_r.st == ST_FETCHW && s_r.phase == PH_CMD && !buf_rdata_i[7]
        && s_r.seg_ptr != SEG_LAST |=> s_r.cnt == $past(buf_rdata_i[6:0])
        ##1 s_r.st == ST_FETCHW) else $error("data command misread");
    chk_end_op: assert property (
        s_r.st == ST_FETCHW && s_r.phase == PH_CMD && buf_rdata_i == OP_END
        |=> s_r.st == ST_DONE ##1 !busy) else $error("end order not honoured");
    chk_protect_ignore: assert property (
        !busy && !s_r.wr_en && is_save_wr && !(is_load_wr && sel_low)
        |=> !busy ##1 !s_r.save) else $error("protected save started");

    cov_save_done: cover property (s_r.save && s_r.st == ST_DONE);
    cov_load_done: cover property (!s_r.save && s_r.st == ST_DONE);
    cov_update_op: cover property (update_o);
    cov_data_error: cover property (busy && s_r.err);
endmodule
`default_nettype wire

/* dv/cfgst_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Buffer bank and store behind the block; ack delay and data errors on demand
module cfgst_far_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [11:0] buf_addr_i,
    input wire logic buf_rd_i,
    output logic [7:0] buf_rdata_o,
    input wire logic buf_wr_i,
    input wire logic [7:0] buf_wdata_i,
    input wire logic nv_req_i,
    input wire logic nv_we_i,
    input wire logic [9:0] nv_addr_i,
    input wire logic [7:0] nv_wdata_i,
    output logic nv_ack_o,
    output logic [7:0] nv_rdata_o,
    output logic nv_err_o,
    input wire logic slow_i,
    input wire logic err_i
);
    logic [7:0] buf_mem [4096];
    logic [7:0] nv_mem [1024];
    int nv_ops = 0;
    int wait_c = 0;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nv_ack_o <= 1'b0;
            nv_err_o <= 1'b0;
            buf_rdata_o <= 8'h00;
            nv_rdata_o <= 8'h00;
            wait_c <= 0;
        end else begin
            nv_ack_o <= 1'b0;
            nv_err_o <= 1'b0;
            // Idle data lines toggle so a stale byte never passes as valid
            buf_rdata_o <= buf_rd_i ? buf_mem[buf_addr_i] : ~buf_rdata_o;
            nv_rdata_o <= ~nv_rdata_o;
            if (buf_wr_i) buf_mem[buf_addr_i] <= buf_wdata_i;
            if (nv_req_i && !nv_ack_o && wait_c < (slow_i ? 4 : 0)) begin
                wait_c <= wait_c + 1;
            end else if (nv_req_i && !nv_ack_o) begin
                wait_c <= 0;
                nv_ack_o <= 1'b1;
                nv_ops <= nv_ops + 1;
                nv_err_o <= err_i;
                if (nv_we_i) nv_mem[nv_addr_i] <= nv_wdata_i;
                else nv_rdata_o <= nv_mem[nv_addr_i];
            end
        end
    end
endmodule
`default_nettype wire

/* dv/config_store_transfer_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module config_store_transfer_ctrl_tb import cfgst_pkg::*;;
    logic clk, rst_n, wr, ssel, psel, slow, err, smp, smp_q;
    logic status, softr, upd, brd, bwr, nvreq, nvwe, nvack, nverr;
    logic [11:0] addr, baddr;
    logic [9:0] nvaddr;
    logic [7:0] wdata, rdata, brdata, bwdata, nvwdata, nvrdata, d0, d1, n0, n1;
    logic [7:0] expq [$];
    logic [31:0] rng = 32'h00000041;
    int err_total = 0, compares = 0, soft_cnt = 0, upd_cnt = 0;
    cfgst_ctrl dut_u (.clock_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .status_sel_i(psel), .status_o(status), .store_sel_i(ssel),
        .soft_reset_o(softr), .update_o(upd), .buf_addr_o(baddr),
        .buf_rd_o(brd), .buf_rdata_i(brdata), .buf_wr_o(bwr),
        .buf_wdata_o(bwdata), .nv_req_o(nvreq), .nv_we_o(nvwe),
        .nv_addr_o(nvaddr), .nv_wdata_o(nvwdata), .nv_ack_i(nvack),
        .nv_rdata_i(nvrdata), .nv_err_i(nverr));
    cfgst_far_model far_u (.clock_i(clk), .rst_n_i(rst_n), .buf_addr_i(baddr),
        .buf_rd_i(brd), .buf_rdata_o(brdata), .buf_wr_i(bwr),
        .buf_wdata_i(bwdata), .nv_req_i(nvreq), .nv_we_i(nvwe),
        .nv_addr_i(nvaddr), .nv_wdata_i(nvwdata), .nv_ack_o(nvack),
        .nv_rdata_o(nvrdata), .nv_err_o(nverr), .slow_i(slow), .err_i(err));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // Read data is registered, so the monitor compares one cycle later
    task rd_reg(input logic [11:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        smp = 1'b1;
        expq.push_back(exp);
        @(negedge clk);
        smp = 1'b0;
    endtask
    task wait_idle();
        int i;
        for (i = 0; i < 3000; i++) begin
            @(negedge clk);
            if (status !== 1'b1) break;
        end
        if (i == 3000) begin
            err_total++;
            $display("mismatch wait_idle expected 0 seen 1");
            final_report();
        end
    endtask
    always @(posedge clk) smp_q <= smp;
    always @(negedge clk) if (smp_q) chk("reg_rdata", expq.pop_front(), rdata);
    always @(posedge clk) begin
        if (rst_n) begin
            soft_cnt += int'(softr);
            upd_cnt += int'(upd);
        end
    end
    initial begin
        rst_n = 0; wr = 0; addr = 12'h000; wdata = 8'h00; smp = 0; smp_q = 0;
        ssel = 1; psel = 1; slow = 1; err = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        rd_reg(REG_PROGRESS, 8'h00);
        rd_reg(REG_DATA_ERROR, 8'h00);
        rd_reg(REG_STORE_CONTROL, 8'h00);
        rd_reg(REG_SAVE_START, 8'h00);
        rd_reg(12'h123, 8'h00);
        // Two bytes at 0x010, then update, then end
        far_u.buf_mem[12'ha00] = 8'h01;
        far_u.buf_mem[12'ha01] = 8'h00;
        far_u.buf_mem[12'ha02] = 8'h10;
        far_u.buf_mem[12'ha03] = OP_UPDATE;
        far_u.buf_mem[12'ha04] = OP_END;
        d0 = rnd();
        d1 = rnd();
        far_u.buf_mem[12'h010] = d0;
        far_u.buf_mem[12'h011] = d1;
        wr_reg(REG_SAVE_START, 8'h01);
        rd_reg(REG_PROGRESS, 8'h00);
        rd_reg(REG_SAVE_START, 8'h00);
        chk("nv_ops", 8'h00, 8'(far_u.nv_ops));
        wr_reg(REG_STORE_CONTROL, 8'h01);
        wr_reg(REG_SAVE_START, 8'h01);
        rd_reg(REG_SAVE_START, 8'h01);
        rd_reg(REG_PROGRESS, 8'h01);
        chk("status", 8'h01, {7'h00, status});
        psel = 0;
        @(negedge clk);
        chk("status", 8'h00, {7'h00, status});
        psel = 1;
        wait_idle();
        rd_reg(REG_SAVE_START, 8'h00);
        rd_reg(REG_DATA_ERROR, 8'h00);
        chk("nv0", d0, far_u.nv_mem[0]);
        chk("nv1", d1, far_u.nv_mem[1]);
        chk("update", 8'h01, 8'(upd_cnt));
        n0 = rnd();
        n1 = rnd();
        far_u.nv_mem[0] = n0;
        far_u.nv_mem[1] = n1;
        repeat (GAP_CYC) @(negedge clk);
        wr_reg(REG_STORE_CONTROL, 8'h03);
        rd_reg(REG_PROGRESS, 8'h00);
        chk("soft_reset", 8'h00, 8'(soft_cnt));
        ssel = 0;
        slow = 0;
        err = 1;
        repeat (4) @(negedge clk);
        wr_reg(REG_STORE_CONTROL, 8'h03);
        rd_reg(REG_PROGRESS, 8'h01);
        wait_idle();
        rd_reg(REG_STORE_CONTROL, 8'h01);
        rd_reg(REG_DATA_ERROR, 8'h01);
        chk("soft_reset", 8'h01, 8'(soft_cnt));
        chk("buf0", n0, far_u.buf_mem[12'h010]);
        chk("buf1", n1, far_u.buf_mem[12'h011]);
        chk("update", 8'h02, 8'(upd_cnt));
        final_report();
    end
endmodule
`default_nettype wire
